// *** dv/pmb_core_model.sv ***
/*
 * Behavioural model of the processor core facing the power manager block.
 * Assumes it shares the block clock and reset; the bench starts work bursts.
 */
`timescale 1ns/1ps

module pmb_core_model #(
	parameter int DRAIN = 5
) (
	input  wire logic clk,       // Block clock.
	input  wire logic rst_n,     // Asynchronous reset, active low.
	input  wire logic issue,     // Starts a burst of pending work.
	input  wire logic clk_stop,  // Core clocks stopped by the block.
	output logic      idle,      // Nothing pending in the core.
	output logic      stop_lost  // Clocks were stopped with work pending.
);
	logic [7:0] pend_ff;
	logic [7:0] nxt_pend;
	logic       lost_ff;
	logic       nxt_lost;

	always_comb begin
		nxt_pend = pend_ff;
		nxt_lost = lost_ff;
		if (issue) begin
			nxt_pend = 8'(DRAIN);
		end else if (!clk_stop && pend_ff != 8'h00) begin
			nxt_pend = pend_ff - 8'h01;
		end
		if (clk_stop && pend_ff != 8'h00) begin
			nxt_lost = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_ff <= 8'h00;
			lost_ff <= 1'b0;
		end else begin
			pend_ff <= nxt_pend;
			lost_ff <= nxt_lost;
		end
	end

	assign idle      = (pend_ff == 8'h00);
	assign stop_lost = lost_ff;
endmodule : pmb_core_model

// *** dv/power_management_unit_tb.sv ***
/*
 * Self-checking bench of the power manager block with a core model.
 * Assumes package, constants header and core model are compiled first.
 */
`timescale 1ns/1ps
`include "pmb_defines.svh"

module power_management_unit_tb;
	logic        clk = 1'b0, rst_n = 1'b0, req_v = 1'b0, issue = 1'b0;
	logic [2:0]  act = 3'h0, pe;
	logic [1:0]  req_s = 2'h0, pstate;
	logic [15:0] per[5] = '{16'h0004, 16'h0008, 16'h000C, 16'h0006, 16'h0005};
	logic [4:0]  smi_en = 5'h00, smi_clr = 5'h1F, smi_cause, en, acc;
	logic [3:0]  duty[3] = '{4'h0, 4'h0, 4'h0};
	logic [2:0]  off[3] = '{3'h0, 3'h0, 3'h0};
	logic [2:0]  plane_en;
	logic        smi_pulse, clk_stop, resume, per_idle, thr_n, core_idle, stop_lost;
	integer      seed = 85889;
	int          error_cnt = 0, total_checks = 0, d, s, u;
	logic [4:0]  exp_q[$];

	always #20 clk = ~clk;

	pmb_power_manager pmb_power_manager_i (.REF_CLK(clk), .RESET_N(rst_n), .SYS_ACT(act[0]),
		.HK_ACT(act[1]), .PERIPH_ACT(act[2]), .DOZE_PERIOD(per[0]), .STBY_PERIOD(per[1]),
		.SUSPEND_THROTTLE_OUT_PERIOD(per[2]), .HK_PERIOD(per[3]), .PERIPH_PERIOD(per[4]), .SMI_EN(smi_en),
		.SMI_CLR(smi_clr), .STATE_REQ_VALID(req_v), .STATE_REQ(req_s), .CORE_IDLE(core_idle),
		.THR_ON_DUTY(duty[0]), .THR_DOZE_DUTY(duty[1]), .THR_STBY_DUTY(duty[2]),
		.PLANE_OFF_DOZE(off[0]), .PLANE_OFF_STBY(off[1]), .PLANE_OFF_SUSPEND_THROTTLE_OUT(off[2]),
		.SMI_PULSE(smi_pulse), .SMI_CAUSE(smi_cause), .POWER_STATE(pstate),
		.CORE_CLK_STOP(clk_stop), .CORE_RESUME(resume), .PERIPH_IDLE(per_idle),
		.SUSPEND_THROTTLE_OUT_N(thr_n), .PLANE_EN(plane_en));

	pmb_core_model pmb_core_model_i (.clk(clk), .rst_n(rst_n), .issue(issue),
		.clk_stop(clk_stop), .idle(core_idle), .stop_lost(stop_lost));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : check

	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim

	// Each interrupt pulse takes the oldest expected cause off the queue.
	always @(negedge clk) begin
		if (smi_pulse !== 1'b0 && rst_n) begin
			if (exp_q.size() == 0) check(8'h01, 8'h00, "unexpected interrupt");
			else check(8'(smi_cause), 8'(exp_q.pop_front()), "interrupt cause");
		end
	end

	task automatic drain(input int lim);
		for (int k = 0; k < lim && exp_q.size() != 0; k++) @(posedge clk);
		if (exp_q.size() != 0) begin
			check(8'(exp_q.size()), 8'h00, "missing interrupt");
			end_sim();
		end
	endtask : drain

	task automatic wait_stop(input logic v);
		for (int k = 0; k < 30 && clk_stop !== v; k++) @(negedge clk);
		if (clk_stop !== v) begin
			check(8'(clk_stop), 8'(v), "core clock stop timeout");
			end_sim();
		end
	endtask : wait_stop

	task automatic burst(input int b, input int len);
		@(posedge clk);
		act[b] <= 1'b1;
		repeat (len) @(posedge clk);
		act[b] <= 1'b0;
	endtask : burst

	task automatic req(input logic [1:0] st);
		@(posedge clk);
		req_v <= 1'b1;
		req_s <= st;
		@(posedge clk);
		req_v <= 1'b0;
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask : req

	task automatic thr(input int lows);
		int c;
		c = 0;
		repeat (16) begin
			@(negedge clk);
			if (thr_n === 1'b0) c++;
		end
		check(8'(c), 8'(lows), "throttle low cycles");
	endtask : thr

	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		check(8'(pstate), 8'h00, "reset state");
		check(8'(plane_en), 8'h07, "reset planes");
		$display("test reset done");
		d = 2 + ($random(seed) & 3);
		s = d + 3 + ($random(seed) & 3);
		u = s + 3 + ($random(seed) & 3);
		en = 5'($random(seed) & 7);
		@(posedge clk);
		per[0] <= 16'(d);
		per[1] <= 16'(s);
		per[2] <= 16'(u);
		per[3] <= 16'(3 + ($random(seed) & 3));
		per[4] <= 16'(4 + ($random(seed) & 3));
		smi_en <= en;
		smi_clr <= 5'h00;
		acc = 5'h00;
		for (int b = 0; b < 3; b++) begin
			if (en[b]) begin
				acc[b] = 1'b1;
				exp_q.push_back(acc);
			end
		end
		burst(0, 1);
		repeat (u + 6) @(posedge clk);
		drain(1);
		@(negedge clk);
		check(8'(smi_cause), 8'(acc), "sticky causes");
		@(posedge clk);
		smi_clr <= 5'h1F;
		smi_en <= 5'h01;
		exp_q.push_back(5'h01);
		burst(0, u + 3);
		drain(40);
		$display("test timers done");
		smi_en <= 5'h00;
		for (int k = 0; k < 3; k++) begin
			duty[k] <= 4'($random(seed));
			off[k] <= 3'($random(seed));
		end
		for (int k = 0; k < 3; k++) begin
			req(2'(k));
			pe = (k == 0) ? 3'h7 : ~off[k - 1];
			check(8'(pstate), 8'(k), "power state");
			check(8'(plane_en), 8'(pe), "planes");
			thr(duty[k]);
		end
		@(posedge clk);
		smi_en <= 5'h08;
		exp_q.push_back(5'h08);
		burst(0, 1);
		drain(10);
		@(negedge clk);
		check(8'(pstate), 8'h02, "wake keeps state");
		burst(1, 2);
		repeat (10) @(posedge clk);
		exp_q.push_back(5'h08);
		burst(1, 12);
		drain(20);
		$display("test states done");
		@(posedge clk);
		issue <= 1'b1;
		@(posedge clk);
		issue <= 1'b0;
		req(2'h3);
		wait_stop(1'b1);
		check(8'(core_idle), 8'h01, "core drained");
		req(2'h0);
		check(8'(pstate), 8'h03, "suspend holds");
		pe = ~off[2];
		check(8'(plane_en), 8'(pe), "suspend planes");
		thr(16);
		exp_q.push_back(5'h08);
		burst(0, 1);
		wait_stop(1'b0);
		check(8'(resume), 8'h01, "resume pulse");
		check(8'(pstate), 8'h00, "back on");
		drain(10);
		check(8'(stop_lost), 8'h00, "stop with work pending");
		$display("test suspend done");
		@(posedge clk);
		smi_en <= 5'h10;
		exp_q.push_back(5'h10);
		burst(2, 1);
		drain(20);
		@(negedge clk);
		check(8'(per_idle), 8'h01, "peripheral idle");
		exp_q.push_back(5'h10);
		burst(2, 1);
		@(negedge clk);
		check(8'(per_idle), 8'h00, "peripheral busy");
		drain(20);
		$display("test peripheral done");
		end_sim();
	end
endmodule : power_management_unit_tb

// *** include/pmb_defines.svh ***
/*
 * Constants of the power manager block: power-state codes, event bit positions
 * and default widths. Assumes inclusion by the package and the design module.
 */
// Operation
// RULE1: Three system inactivity timers, doze, stand-by and suspend, of rising length.
// RULE2: Any expiring inactivity timer can raise a management interrupt to the core.
// RULE3: System activity in any power-down state can raise a management interrupt.
// RULE4: Power-down states doze, stand-by and suspend beside full on, by falling power.
// RULE5: A house-keeping timer absorbs short house-keeping bursts during doze or stand-by.
// RULE6: An independent peripheral timer flags absence of peripheral activity.
// RULE7: The suspend output is modulated to throttle performance in every power state; the code holds it low throughout suspend.
// RULE8: Power-control outputs switch board power planes off per power state.
// RULE9: Suspend is entered only once the core has finished instructions and bus cycles.
// RULE10: In suspend the core clocks stop and all internal state is held.
// RULE11: Leaving suspend, the core resumes fetching exactly where it stopped.
// RULE12: Inactivity timers reload on their activity and count only while it is absent.
`ifndef PMB_DEFINES_SVH
`define PMB_DEFINES_SVH

`define PMB_PS_ON       2'h0
`define PMB_PS_DOZE     2'h1
`define PMB_PS_STBY     2'h2
`define PMB_PS_SUSPEND_THROTTLE_OUT     2'h3

`define PMB_EV_DOZE     0
`define PMB_EV_STBY     1
`define PMB_EV_SUSPEND_THROTTLE_OUT     2
`define PMB_EV_WAKE     3
`define PMB_EV_PERIPH   4
`define PMB_EV_W        5

`define PMB_TMR_W       16
`define PMB_THR_W       4
`define PMB_PLANE_N     3

`endif

// *** include/pmb_pkg.sv ***
/*
 * Types of the power manager block.
 * Assumes the constants header is on the include path.
 */
`include "pmb_defines.svh"

package pmb_pkg;

	typedef enum logic [2:0] {
		ST_ON,
		ST_DOZE,
		ST_STBY,
		ST_SUSPEND_THROTTLE_OUT_WAIT,
		ST_SUSPEND_THROTTLE_OUT
	} pmb_state_e;

	typedef logic [`PMB_EV_W-1:0] pmb_ev_t;

endpackage : pmb_pkg

// *** rtl/pmb_power_manager.sv ***
/*
 * Power manager block: inactivity timers, management interrupt requests,
 * power-state sequencing with core clock stop and resume, suspend throttling
 * and power-plane control.
 * Assumes all inputs are synchronous to REF_CLK and that management software
 * steers states through the request port and clears causes through SMI_CLR.
 */
`timescale 1ns/1ps
`include "pmb_defines.svh"

module pmb_power_manager
	import pmb_pkg::*;
#(
	parameter int TMR_W   = `PMB_TMR_W,
	parameter int THR_W   = `PMB_THR_W,
	parameter int PLANE_N = `PMB_PLANE_N
) (
	input  wire logic               REF_CLK,                // Block clock, 25 MHz.
	input  wire logic               RESET_N,                // Asynchronous reset.
	input  wire logic               SYS_ACT,                // System activity seen.
	input  wire logic               HK_ACT,                 // House-keeping activity.
	input  wire logic               PERIPH_ACT,             // Peripheral activity.
	input  wire logic [TMR_W-1:0]   DOZE_PERIOD,            // Short idle period.
	input  wire logic [TMR_W-1:0]   STBY_PERIOD,            // Medium idle period.
	input  wire logic [TMR_W-1:0]   SUSPEND_THROTTLE_OUT_PERIOD,            // Long idle period.
	input  wire logic [TMR_W-1:0]   HK_PERIOD,              // Burst length that forces a wake.
	input  wire logic [TMR_W-1:0]   PERIPH_PERIOD,          // Peripheral idle period.
	input  wire logic [`PMB_EV_W-1:0] SMI_EN,               // Per-event interrupt enable.
	input  wire logic [`PMB_EV_W-1:0] SMI_CLR,              // Clears cause bits.
	input  wire logic               STATE_REQ_VALID,        // Software state request.
	input  wire logic [1:0]         STATE_REQ,              // Requested power state.
	input  wire logic               CORE_IDLE,              // Core has drained.
	input  wire logic [THR_W-1:0]   THR_ON_DUTY,            // Throttle duty, full on.
	input  wire logic [THR_W-1:0]   THR_DOZE_DUTY,          // Throttle duty, doze.
	input  wire logic [THR_W-1:0]   THR_STBY_DUTY,          // Throttle duty, stand-by.
	input  wire logic [PLANE_N-1:0] PLANE_OFF_DOZE,         // Planes off in doze.
	input  wire logic [PLANE_N-1:0] PLANE_OFF_STBY,         // Planes off in stand-by.
	input  wire logic [PLANE_N-1:0] PLANE_OFF_SUSPEND_THROTTLE_OUT,         // Planes off in suspend.
	output logic                    SMI_PULSE,              // Management interrupt.
	output logic [`PMB_EV_W-1:0]    SMI_CAUSE,              // Sticky event causes.
	output logic [1:0]              POWER_STATE,            // Current power state.
	output logic                    CORE_CLK_STOP,          // Core clocks stopped.
	output logic                    CORE_RESUME,            // Core restart pulse.
	output logic                    PERIPH_IDLE,            // Peripherals idle.
	output logic                    SUSPEND_THROTTLE_OUT_N, // Low stalls the system.
	output logic [PLANE_N-1:0]      PLANE_EN                // Power plane enables.
);

	if (TMR_W < 2 || TMR_W > 32 || THR_W < 1 || THR_W > 8 || PLANE_N < 1) begin : g_chk
		$error("pmb_power_manager: unsupported parameter values");
	end

	function automatic logic [TMR_W-1:0] tmr_next(input logic [TMR_W-1:0] cnt,
		input logic [TMR_W-1:0] period, input logic load);
		logic [TMR_W-1:0] res;
		res = cnt;
		if (load)
			res = period;
		else if (cnt != '0)
			res = cnt - 1'b1;
		return res;
	endfunction : tmr_next

	function automatic logic tmr_expire(input logic [TMR_W-1:0] cnt, input logic load);
		return !load && (cnt == {{(TMR_W-1){1'b0}}, 1'b1});
	endfunction : tmr_expire

	logic [TMR_W-1:0]     doze_cnt_ff, stby_cnt_ff, suspend_throttle_out_cnt_ff, hk_cnt_ff, per_cnt_ff;
	logic [TMR_W-1:0]     nxt_doze_cnt, nxt_stby_cnt, nxt_suspend_throttle_out_cnt, nxt_hk_cnt, nxt_per_cnt;
	logic                 hk_window;
	logic                 hk_load;
	logic                 hk_expire;
	logic                 wake_evt;
	pmb_ev_t              ev;
	pmb_state_e           state_ff, nxt_state;
	pmb_ev_t              cause_ff, nxt_cause;
	logic                 smi_ff, nxt_smi;
	logic                 resume_ff, nxt_resume;
	logic                 per_idle_ff, nxt_per_idle;
	logic [THR_W-1:0]     phase_ff, nxt_phase;
	logic                 thr_n_ff, nxt_thr_n;
	logic [PLANE_N-1:0]   plane_ff, nxt_plane;
	logic [1:0]           ps_ff, nxt_ps;
	logic [THR_W-1:0]     duty;

	// Timers and event detection.
	always_comb begin
		hk_window = (state_ff == ST_DOZE) || (state_ff == ST_STBY);
		// The house-keeping timer runs only while a burst lasts; a burst shorter
		// than its period never turns into a wake event.
		hk_load      = !(HK_ACT && hk_window);                          // [RULE5]
		hk_expire    = tmr_expire(hk_cnt_ff, hk_load);                  // [RULE5]
		nxt_hk_cnt   = tmr_next(hk_cnt_ff, HK_PERIOD, hk_load);         // [RULE5]
		nxt_doze_cnt = tmr_next(doze_cnt_ff, DOZE_PERIOD, SYS_ACT);     // [RULE1] [RULE12]
		nxt_stby_cnt = tmr_next(stby_cnt_ff, STBY_PERIOD, SYS_ACT);     // [RULE1] [RULE12]
		nxt_suspend_throttle_out_cnt = tmr_next(suspend_throttle_out_cnt_ff, SUSPEND_THROTTLE_OUT_PERIOD, SYS_ACT);     // [RULE1] [RULE12]
		nxt_per_cnt  = tmr_next(per_cnt_ff, PERIPH_PERIOD, PERIPH_ACT); // [RULE6] [RULE12]
		wake_evt     = (state_ff != ST_ON) && (SYS_ACT || hk_expire);   // [RULE3]
		ev = '0;
		ev[`PMB_EV_DOZE]   = tmr_expire(doze_cnt_ff, SYS_ACT);          // [RULE2]
		ev[`PMB_EV_STBY]   = tmr_expire(stby_cnt_ff, SYS_ACT);          // [RULE2]
		ev[`PMB_EV_SUSPEND_THROTTLE_OUT]   = tmr_expire(suspend_throttle_out_cnt_ff, SYS_ACT);          // [RULE2]
		ev[`PMB_EV_WAKE]   = wake_evt;                                  // [RULE3]
		ev[`PMB_EV_PERIPH] = tmr_expire(per_cnt_ff, PERIPH_ACT);        // [RULE6]
		nxt_per_idle = PERIPH_ACT ? 1'b0 : (per_idle_ff || ev[`PMB_EV_PERIPH]); // [RULE6]
		nxt_smi   = |(ev & SMI_EN);                                     // [RULE2] [RULE3]
		// A new event beats a clear arriving in the same cycle.
		nxt_cause = (cause_ff & ~SMI_CLR) | (ev & SMI_EN);
	end

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			doze_cnt_ff <= '0;
			stby_cnt_ff <= '0;
			suspend_throttle_out_cnt_ff <= '0;
			hk_cnt_ff   <= '0;
			per_cnt_ff  <= '0;
			per_idle_ff <= 1'b0;
			smi_ff      <= 1'b0;
			cause_ff    <= '0;
		end else begin
			doze_cnt_ff <= nxt_doze_cnt;
			stby_cnt_ff <= nxt_stby_cnt;
			suspend_throttle_out_cnt_ff <= nxt_suspend_throttle_out_cnt;
			hk_cnt_ff   <= nxt_hk_cnt;
			per_cnt_ff  <= nxt_per_cnt;
			per_idle_ff <= nxt_per_idle;
			smi_ff      <= nxt_smi;
			cause_ff    <= nxt_cause;
		end
	end

	// Power-state sequencing.
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_ON, ST_DOZE, ST_STBY, ST_SUSPEND_THROTTLE_OUT_WAIT: begin
				if (STATE_REQ_VALID) begin
					case (STATE_REQ)                                    // [RULE4]
						`PMB_PS_ON:   nxt_state = ST_ON;
						`PMB_PS_DOZE: nxt_state = ST_DOZE;
						`PMB_PS_STBY: nxt_state = ST_STBY;
						default:      nxt_state = ST_SUSPEND_THROTTLE_OUT_WAIT;
					endcase
				end else if (state_ff == ST_SUSPEND_THROTTLE_OUT_WAIT && wake_evt) begin
					nxt_state = ST_ON;
				end else if (state_ff == ST_SUSPEND_THROTTLE_OUT_WAIT && CORE_IDLE) begin
					nxt_state = ST_SUSPEND_THROTTLE_OUT;                                // [RULE9]
				end
			end
			// Software cannot run with the core stopped, so a wake event exits.
			ST_SUSPEND_THROTTLE_OUT: begin
				if (wake_evt)
					nxt_state = ST_ON;                                  // [RULE11]
			end
			default: nxt_state = ST_ON;
		endcase
		nxt_resume = (state_ff == ST_SUSPEND_THROTTLE_OUT) && (nxt_state != ST_SUSPEND_THROTTLE_OUT);   // [RULE11]
		case (nxt_state)
			ST_DOZE:      nxt_ps = `PMB_PS_DOZE;
			ST_STBY:      nxt_ps = `PMB_PS_STBY;
			ST_SUSPEND_THROTTLE_OUT_WAIT: nxt_ps = `PMB_PS_STBY;
			ST_SUSPEND_THROTTLE_OUT:      nxt_ps = `PMB_PS_SUSPEND_THROTTLE_OUT;
			default:      nxt_ps = `PMB_PS_ON;
		endcase
	end

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_ff  <= ST_ON;
			resume_ff <= 1'b0;
			ps_ff     <= `PMB_PS_ON;
		end else begin
			state_ff  <= nxt_state;
			resume_ff <= nxt_resume;
			ps_ff     <= nxt_ps;
		end
	end

	// Throttling and power planes follow the registered state.
	always_comb begin
		case (state_ff)
			ST_DOZE:                duty = THR_DOZE_DUTY;
			ST_STBY, ST_SUSPEND_THROTTLE_OUT_WAIT:  duty = THR_STBY_DUTY;
			default:                duty = THR_ON_DUTY;
		endcase
		nxt_phase = phase_ff + 1'b1;
		nxt_thr_n = (state_ff == ST_SUSPEND_THROTTLE_OUT) ? 1'b0 : !(phase_ff < duty);  // [RULE7]
		case (state_ff)
			ST_DOZE:                nxt_plane = ~PLANE_OFF_DOZE;         // [RULE8]
			ST_STBY, ST_SUSPEND_THROTTLE_OUT_WAIT:  nxt_plane = ~PLANE_OFF_STBY;         // [RULE8]
			ST_SUSPEND_THROTTLE_OUT:                nxt_plane = ~PLANE_OFF_SUSPEND_THROTTLE_OUT;         // [RULE8]
			default:                nxt_plane = '1;
		endcase
	end

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			phase_ff <= '0;
			thr_n_ff <= 1'b1;
			plane_ff <= '1;
		end else begin
			phase_ff <= nxt_phase;
			thr_n_ff <= nxt_thr_n;
			plane_ff <= nxt_plane;
		end
	end

	// The core keeps its state while stopped; only its clock is gated.
	assign CORE_CLK_STOP          = (state_ff == ST_SUSPEND_THROTTLE_OUT);              // [RULE10]
	assign SMI_PULSE              = smi_ff;
	assign SMI_CAUSE              = cause_ff;
	assign POWER_STATE            = ps_ff;
	assign CORE_RESUME            = resume_ff;
	assign PERIPH_IDLE            = per_idle_ff;
	assign SUSPEND_THROTTLE_OUT_N = thr_n_ff;
	assign PLANE_EN               = plane_ff;

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RESET_N);

	property p_reload;
		SYS_ACT |=> doze_cnt_ff == $past(DOZE_PERIOD) && suspend_throttle_out_cnt_ff == $past(SUSPEND_THROTTLE_OUT_PERIOD);
	endproperty
	a_reload: assert property (p_reload) else $error("timer did not reload"); // [RULE12]

	property p_countdown;
		!SYS_ACT && stby_cnt_ff > 1 |=> stby_cnt_ff == $past(stby_cnt_ff) - 1'b1;
	endproperty
	a_countdown: assert property (p_countdown) else $error("timer not counting"); // [RULE1]

	property p_expire_smi;
		!SYS_ACT && doze_cnt_ff == 1 && SMI_EN[`PMB_EV_DOZE]
			|=> SMI_PULSE && SMI_CAUSE[`PMB_EV_DOZE];
	endproperty
	a_expire_smi: assert property (p_expire_smi) else $error("no expiry interrupt"); // [RULE2]

	property p_wake_smi;
		state_ff != ST_ON && SYS_ACT && SMI_EN[`PMB_EV_WAKE] |=> SMI_PULSE;
	endproperty
	a_wake_smi: assert property (p_wake_smi) else $error("no wake interrupt"); // [RULE3]

	property p_hk_absorb;
		hk_window && HK_ACT && !SYS_ACT && hk_cnt_ff > 1 && !STATE_REQ_VALID
			|-> !wake_evt ##1 state_ff == $past(state_ff);
	endproperty
	a_hk_absorb: assert property (p_hk_absorb) else $error("burst forced wake"); // [RULE5]

	property p_periph_idle;
		!PERIPH_ACT && per_cnt_ff == 1 |=> PERIPH_IDLE;
	endproperty
	a_periph_idle: assert property (p_periph_idle) else $error("periph idle missing"); // [RULE6]

	property p_throttle;
		state_ff == ST_SUSPEND_THROTTLE_OUT |=> !SUSPEND_THROTTLE_OUT_N;
	endproperty
	a_throttle: assert property (p_throttle) else $error("throttle not held"); // [RULE7]

	property p_planes;
		state_ff == ST_DOZE |=> PLANE_EN == ~$past(PLANE_OFF_DOZE);
	endproperty
	a_planes: assert property (p_planes) else $error("plane enables wrong"); // [RULE8]

	property p_drain;
		$rose(CORE_CLK_STOP) |-> $past(CORE_IDLE) && $past(state_ff) == ST_SUSPEND_THROTTLE_OUT_WAIT;
	endproperty
	a_drain: assert property (p_drain) else $error("suspend before drain"); // [RULE9]

	property p_hold;
		CORE_CLK_STOP && !SYS_ACT |=> CORE_CLK_STOP;
	endproperty
	a_hold: assert property (p_hold) else $error("clock restarted early"); // [RULE10]

	property p_resume;
		$fell(CORE_CLK_STOP) |-> CORE_RESUME ##1 !CORE_RESUME;
	endproperty
	a_resume: assert property (p_resume) else $error("no resume pulse"); // [RULE11]

	property p_state_code;
		state_ff == ST_SUSPEND_THROTTLE_OUT |-> POWER_STATE == `PMB_PS_SUSPEND_THROTTLE_OUT;
	endproperty
	a_state_code: assert property (p_state_code) else $error("state code wrong"); // [RULE4]

	property p_resume_src;
		CORE_RESUME |-> $past(state_ff) == ST_SUSPEND_THROTTLE_OUT && state_ff == ST_ON;
	endproperty
	a_resume_src: assert property (p_resume_src) else $error("stray resume pulse"); // [RULE11]

	property p_req_doze;
		STATE_REQ_VALID && STATE_REQ == `PMB_PS_DOZE && state_ff != ST_SUSPEND_THROTTLE_OUT
			|=> state_ff == ST_DOZE;
	endproperty
	a_req_doze: assert property (p_req_doze) else $error("doze request lost"); // [RULE4]

	property p_planes_suspend_throttle_out;
		state_ff == ST_SUSPEND_THROTTLE_OUT |=> PLANE_EN == ~$past(PLANE_OFF_SUSPEND_THROTTLE_OUT);
	endproperty
	a_planes_suspend_throttle_out: assert property (p_planes_suspend_throttle_out) else $error("suspend planes wrong"); // [RULE8]

	property p_periph_busy;
		PERIPH_ACT |=> !PERIPH_IDLE;
	endproperty
	a_periph_busy: assert property (p_periph_busy) else $error("idle flag not cleared"); // [RULE6]

endmodule : pmb_power_manager
